/* File: logic/orlm_top.sv */
//
// Overview of operation
// - Bytes 0-31 hold a 256-bit private key, MSB first, under secret lock.
// - A factory-programmed secret region is locked by boot exit.
// - An unprogrammed secret region stays unlocked after boot exit.
// - Bytes 32-127 are factory reserved; factory lock set at boot exit.
// - Bytes 128-191 hold public key X then Y; boot never locks them.
// - Bytes 192-415 are customer storage; boot exit leaves customer lock clear.
// - Bytes 416-479 hold a second public key under the open customer lock.
// - Byte 482 bit 6 picks the debug protocol: one serial wire, zero four-wire.
// - Byte 482 bit 7 set disables both debug protocols at boot exit.
// - A locked region refuses programming and reads back as zero.
// - Four lock bits, one per region, sit in one lock register.
//
`timescale 1ns/1ps
`default_nettype none
`include "orlm_consts.svh"

module orlm_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic FUSE_REQ,
	output logic FUSE_PROG,
	output orlm_pkg::orlm_bitaddr_t FUSE_ADDR,
	input wire logic [7:0] FUSE_RDATA,
	output logic [3:0] LOCK,
	output logic DBG_SWD_SEL,
	output logic DBG_ENABLE,
	output logic BOOT_DONE
);
	import orlm_pkg::*;

	// Bit address of bit zero of a fuse byte, shared by every byte read
	function automatic orlm_bitaddr_t byte_bitaddr(input orlm_byte_t b);
		return {b, 3'h0};
	endfunction

	// ----------------------------------------
	// Lock storage and access gate
	// ----------------------------------------
	orlm_lock_if li ();

	// Set-only lock bits, cleared by reset alone
	orlm_lock_regs u_lock (
		.clk(MCLK),
		.rst_n(RST_N),
		.li(li)
	);

	// Lock lookup for the byte that software addresses
	orlm_fuse_gate u_gate (
		.li(li)
	);

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	orlm_state_t state_r, state_nxt;
	orlm_byte_t idx_r, idx_nxt;
	orlm_bitaddr_t addr_r, addr_nxt;
	logic [7:0] data_r, data_nxt;
	logic key_prog_r, key_prog_nxt;
	logic scanned_r, scanned_nxt;
	logic exited_r, exited_nxt;
	logic exit_pend_r, exit_pend_nxt;
	logic blocked_r, blocked_nxt;
	logic swd_sel_r, swd_sel_nxt;
	logic dbg_dis_r, dbg_dis_nxt;
	logic dbg_en_r, dbg_en_nxt;
	logic freq_r, freq_nxt;
	logic fprog_r, fprog_nxt;
	orlm_bitaddr_t faddr_r, faddr_nxt;
	logic [3:0] sw_set;
	logic [3:0] hw_set;

	// ----------------------------------------
	// Register bus read register and write strobe decode
	// ----------------------------------------
	logic [31:0] rdata_r, rdata_nxt;

	// Strobe decode
	logic wr_lock, wr_ctrl, wr_addr, wr_cmd;
	assign wr_lock = WR && (ADDR == `ORLM_OFF_LOCK);
	assign wr_ctrl = WR && (ADDR == `ORLM_OFF_CTRL);
	assign wr_addr = WR && (ADDR == `ORLM_OFF_ADDR);
	assign wr_cmd = WR && (ADDR == `ORLM_OFF_CMD);

	// Boot exit request from software, honoured only once per reset
	logic exit_req;
	assign exit_req = wr_ctrl && WDATA[`ORLM_CTRL_EXIT] && !exited_r;

	// Software may only add lock bits
	assign sw_set = wr_lock ? WDATA[3:0] : 4'h0;
	assign li.sw_set = sw_set;
	assign li.hw_set = hw_set;

	// Gate query: scan traffic bypasses it, software traffic uses the byte field
	assign li.q_byte = addr_r[11:3];

	// ----------------------------------------
	// Next-state logic of the control group
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		key_prog_nxt = key_prog_r;
		scanned_nxt = scanned_r;
		exited_nxt = exited_r;
		exit_pend_nxt = exit_pend_r;
		blocked_nxt = blocked_r;
		swd_sel_nxt = swd_sel_r;
		dbg_dis_nxt = dbg_dis_r;
		dbg_en_nxt = dbg_en_r;
		freq_nxt = 1'b0;
		fprog_nxt = 1'b0;
		faddr_nxt = faddr_r;
		hw_set = 4'h0;

		// Address field is writable whenever no software access is in flight
		if (wr_addr && (state_r != ORLM_RD_CAP)) begin
			addr_nxt = WDATA[11:0];
		end

		// Boot exit request is held until the configuration scan is done
		if (exit_req) begin
			exit_pend_nxt = 1'b1;
		end

		unique case (state_r)
			// Read key bytes; any nonzero byte means the factory wrote the key
			ORLM_SCAN_REQ: begin
				freq_nxt = 1'b1;
				faddr_nxt = byte_bitaddr(idx_r);
				state_nxt = ORLM_SCAN_CAP;
			end
			ORLM_SCAN_CAP: begin
				if (FUSE_RDATA != 8'h00) begin
					key_prog_nxt = 1'b1;
				end
				if (idx_r == `ORLM_SECRET_LAST) begin
					state_nxt = ORLM_DBG_REQ;
				end else begin
					idx_nxt = idx_r + 9'h001;
					state_nxt = ORLM_SCAN_REQ;
				end
			end
			// Fetch the debug configuration byte
			ORLM_DBG_REQ: begin
				freq_nxt = 1'b1;
				faddr_nxt = byte_bitaddr(`ORLM_DBG_BYTE);
				state_nxt = ORLM_DBG_CAP;
			end
			ORLM_DBG_CAP: begin
				// Bits 5:0 are test bits and are left alone
				swd_sel_nxt = FUSE_RDATA[`ORLM_DBG_SEL_POS];
				dbg_dis_nxt = FUSE_RDATA[`ORLM_DBG_DIS_POS];
				scanned_nxt = 1'b1;
				state_nxt = ORLM_IDLE;
			end
			// Serve boot exit and software fuse commands
			ORLM_IDLE: begin
				if (exit_pend_r || exit_req) begin
					// Factory lock always, secret lock only for a factory key
					hw_set[`ORLM_LK_FACTORY] = 1'b1;
					hw_set[`ORLM_LK_SECRET] = key_prog_r;
					// Public and customer locks are left to software
					hw_set[`ORLM_LK_PUBLIC] = 1'b0;
					hw_set[`ORLM_LK_CUSTOMER] = 1'b0;
					exited_nxt = 1'b1;
					exit_pend_nxt = 1'b0;
					dbg_en_nxt = !dbg_dis_r;
				end else if (wr_cmd && WDATA[`ORLM_CMD_PROG]) begin
					blocked_nxt = li.q_blocked;
					if (!li.q_blocked) begin
						fprog_nxt = 1'b1;
						freq_nxt = 1'b1;
						faddr_nxt = addr_r;
					end
				end else if (wr_cmd && WDATA[`ORLM_CMD_READ]) begin
					blocked_nxt = li.q_blocked;
					if (li.q_blocked) begin
						data_nxt = 8'h00;
					end else begin
						freq_nxt = 1'b1;
						faddr_nxt = byte_bitaddr(addr_r[11:3]);
						state_nxt = ORLM_RD_CAP;
					end
				end
			end
			// Capture the byte; a lock set meanwhile still forces zero
			ORLM_RD_CAP: begin
				data_nxt = li.q_blocked ? 8'h00 : FUSE_RDATA;
				blocked_nxt = li.q_blocked;
				state_nxt = ORLM_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Control group registers
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= ORLM_SCAN_REQ;
			idx_r <= 9'h000;
			addr_r <= 12'h000;
			data_r <= 8'h00;
			key_prog_r <= 1'b0;
			scanned_r <= 1'b0;
			exited_r <= 1'b0;
			exit_pend_r <= 1'b0;
			blocked_r <= 1'b0;
			swd_sel_r <= 1'b0;
			dbg_dis_r <= 1'b0;
			dbg_en_r <= 1'b1;
			freq_r <= 1'b0;
			fprog_r <= 1'b0;
			faddr_r <= 12'h000;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			key_prog_r <= key_prog_nxt;
			scanned_r <= scanned_nxt;
			exited_r <= exited_nxt;
			exit_pend_r <= exit_pend_nxt;
			blocked_r <= blocked_nxt;
			swd_sel_r <= swd_sel_nxt;
			dbg_dis_r <= dbg_dis_nxt;
			dbg_en_r <= dbg_en_nxt;
			freq_r <= freq_nxt;
			fprog_r <= fprog_nxt;
			faddr_r <= faddr_nxt;
		end
	end

	// ----------------------------------------
	// Read data mux, answered one cycle after the strobe
	// ----------------------------------------
	always_comb begin
		rdata_nxt = 32'h00000000;
		if (RD) begin
			unique case (ADDR)
				`ORLM_OFF_LOCK: begin
					rdata_nxt = {28'h0000000, li.lock};
				end
				`ORLM_OFF_STATUS: begin
					rdata_nxt[`ORLM_ST_SCANNED] = scanned_r;
					rdata_nxt[`ORLM_ST_EXITED] = exited_r;
					rdata_nxt[`ORLM_ST_KEYPROG] = key_prog_r;
					rdata_nxt[`ORLM_ST_BUSY] = (state_r != ORLM_IDLE);
					rdata_nxt[`ORLM_ST_BLOCKED] = blocked_r;
					rdata_nxt[`ORLM_ST_EXITPEND] = exit_pend_r;
				end
				`ORLM_OFF_ADDR: begin
					rdata_nxt = {20'h00000, addr_r};
				end
				`ORLM_OFF_DATA: begin
					rdata_nxt = {24'h000000, data_r};
				end
				`ORLM_OFF_DEBUG: begin
					rdata_nxt[0] = swd_sel_r;
					rdata_nxt[1] = dbg_dis_r;
					rdata_nxt[2] = dbg_en_r;
				end
				default: begin
					rdata_nxt = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------
	assign RDATA = rdata_r;
	assign FUSE_REQ = freq_r;
	assign FUSE_PROG = fprog_r;
	assign FUSE_ADDR = faddr_r;
	assign LOCK = li.lock;
	assign DBG_SWD_SEL = swd_sel_r;
	assign DBG_ENABLE = dbg_en_r;
	assign BOOT_DONE = exited_r;
endmodule // orlm_top

`default_nettype wire

/* File: pkg/orlm_consts.svh */
`ifndef ORLM_CONSTS_SVH
`define ORLM_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ORLM_OFF_LOCK 8'h00
`define ORLM_OFF_CTRL 8'h04
`define ORLM_OFF_STATUS 8'h08
`define ORLM_OFF_ADDR 8'h0C
`define ORLM_OFF_CMD 8'h10
`define ORLM_OFF_DATA 8'h14
`define ORLM_OFF_DEBUG 8'h18

// ----------------------------------------
// Fuse region bounds (last byte of each)
// ----------------------------------------
`define ORLM_SECRET_LAST 9'h01F
`define ORLM_FACTORY_LAST 9'h07F
`define ORLM_PUBLIC_LAST 9'h0BF
`define ORLM_CUSTOMER_LAST 9'h1FF

// ----------------------------------------
// Lock vector bit positions
// ----------------------------------------
`define ORLM_LK_SECRET 2'h0
`define ORLM_LK_FACTORY 2'h1
`define ORLM_LK_PUBLIC 2'h2
`define ORLM_LK_CUSTOMER 2'h3
`define ORLM_LOCK_RST 4'h0

// ----------------------------------------
// Debug configuration byte
// ----------------------------------------
`define ORLM_DBG_BYTE 9'h1E2
`define ORLM_DBG_SEL_BIT 3
`define ORLM_DBG_SEL_POS 6
`define ORLM_DBG_DIS_POS 7

// ----------------------------------------
// Register field positions
// ----------------------------------------
`define ORLM_CTRL_EXIT 0
`define ORLM_CMD_READ 0
`define ORLM_CMD_PROG 1
`define ORLM_ST_SCANNED 0
`define ORLM_ST_EXITED 1
`define ORLM_ST_KEYPROG 2
`define ORLM_ST_BUSY 3
`define ORLM_ST_BLOCKED 4
`define ORLM_ST_EXITPEND 5

`endif

/* File: pkg/orlm_pkg.sv */
`include "orlm_consts.svh"

package orlm_pkg;

	// Control sequence states
	typedef enum logic [2:0] {
		ORLM_SCAN_REQ,
		ORLM_SCAN_CAP,
		ORLM_DBG_REQ,
		ORLM_DBG_CAP,
		ORLM_IDLE,
		ORLM_RD_CAP
	} orlm_state_t;

	typedef logic [1:0] orlm_region_t;
	typedef logic [8:0] orlm_byte_t;
	typedef logic [11:0] orlm_bitaddr_t;

	// Map a fuse byte number onto the index of its lock bit
	function automatic orlm_region_t orlm_region_of(input orlm_byte_t b);
		if (b <= `ORLM_SECRET_LAST) begin
			return `ORLM_LK_SECRET;
		end else if (b <= `ORLM_FACTORY_LAST) begin
			return `ORLM_LK_FACTORY;
		end else if (b <= `ORLM_PUBLIC_LAST) begin
			return `ORLM_LK_PUBLIC;
		end
		return `ORLM_LK_CUSTOMER;
	endfunction

endpackage

/* File: pkg/orlm_lock_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Lock state, set requests and the access query between block modules
interface orlm_lock_if;
	logic [3:0] lock;
	logic [3:0] sw_set;
	logic [3:0] hw_set;
	logic [8:0] q_byte;
	logic q_blocked;

	modport regs (input sw_set, input hw_set, output lock);
	modport gate (input lock, input q_byte, output q_blocked);
	modport ctrl (input lock, input q_blocked, output sw_set, output hw_set, output q_byte);
endinterface

`default_nettype wire

/* File: logic/orlm_lock_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "orlm_consts.svh"

module orlm_lock_regs (
	input wire logic clk,
	input wire logic rst_n,
	orlm_lock_if.regs li
);
	import orlm_pkg::*;

	logic [3:0] lock_r;
	logic [3:0] lock_nxt;

	// Locks only ever gain bits; nothing but reset clears them
	always_comb begin
		lock_nxt = lock_r | li.sw_set | li.hw_set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_r <= `ORLM_LOCK_RST;
		end else begin
			lock_r <= lock_nxt;
		end
	end

	assign li.lock = lock_r;
endmodule // orlm_lock_regs

`default_nettype wire

/* File: logic/orlm_fuse_gate.sv */
`timescale 1ns/1ps
`default_nettype none

module orlm_fuse_gate (
	orlm_lock_if.gate li
);
	import orlm_pkg::*;

	// A request is blocked while the lock of its region stands
	always_comb begin
		li.q_blocked = li.lock[orlm_region_of(li.q_byte)];
	end
endmodule // orlm_fuse_gate

`default_nettype wire

/* File: verification/orlm_top_props.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------
// Port checker
// ----------------
module orlm_top_props (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic FUSE_REQ,
	input wire logic FUSE_PROG,
	input wire orlm_pkg::orlm_bitaddr_t FUSE_ADDR,
	input wire logic [7:0] FUSE_RDATA,
	input wire logic [3:0] LOCK,
	input wire logic DBG_SWD_SEL,
	input wire logic DBG_ENABLE,
	input wire logic BOOT_DONE
);
	import orlm_pkg::*;
	logic rd_req, knz_r, knz_nxt;
	logic [8:0] fb;
	logic [5:0] n_r, n_nxt;
	logic [7:0] dbg_r, dbg_nxt;
	logic [1:0] rg;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Scan tracking: the array answers in the request cycle; 32 key reads, then byte 482
	always_comb begin
		fb = FUSE_ADDR[11:3];
		rd_req = FUSE_REQ && !FUSE_PROG;
		n_nxt = (rd_req && n_r < 6'h21) ? n_r + 6'h01 : n_r;
		knz_nxt = knz_r | (rd_req && n_r < 6'h20 && FUSE_RDATA != 8'h00);
		dbg_nxt = (rd_req && n_r == 6'h20) ? FUSE_RDATA : dbg_r;
		rg = (fb < 9'h020) ? 2'h0 : (fb < 9'h080) ? 2'h1 : (fb < 9'h0C0) ? 2'h2 : 2'h3;
	end
	// Tracking registers
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			{knz_r, n_r, dbg_r} <= '0;
		end else begin
			{knz_r, n_r, dbg_r} <= {knz_nxt, n_nxt, dbg_nxt};
		end
	end
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data not zero outside read slot");
	lock_sticky_a: assert property ((LOCK & $past(LOCK)) == $past(LOCK))
		else $error("lock bit cleared");
	done_sticky_a: assert property ($past(BOOT_DONE) |-> BOOT_DONE)
		else $error("boot done dropped");
	factory_lock_a: assert property (BOOT_DONE |-> LOCK[1])
		else $error("factory lock open after exit");
	secret_lock_a: assert property (BOOT_DONE && knz_r |-> LOCK[0])
		else $error("programmed key left open");
	public_lock_a: assert property ($rose(LOCK[2]) |-> $past(WR && ADDR == 8'h00 && WDATA[2]))
		else $error("public lock set by hardware");
	cust_lock_a: assert property ($rose(LOCK[3]) |-> $past(WR && ADDR == 8'h00 && WDATA[3]))
		else $error("customer lock set by hardware");
	locked_prog_a: assert property (FUSE_REQ && FUSE_PROG |-> !LOCK[rg])
		else $error("program issued into locked region");
	swd_sel_a: assert property (BOOT_DONE |-> DBG_SWD_SEL == dbg_r[6])
		else $error("debug select wrong");
	dbg_off_a: assert property (BOOT_DONE |-> DBG_ENABLE == !dbg_r[7])
		else $error("debug enable wrong after exit");
	key_scan_a: assert property (FUSE_REQ && !FUSE_PROG && n_r < 6'h20 |->
		FUSE_ADDR == {3'h0, n_r, 3'h0})
		else $error("key scan address out of order");
	cfg_scan_a: assert property (FUSE_REQ && !FUSE_PROG && n_r == 6'h20 |->
		FUSE_ADDR == 12'hF10)
		else $error("debug byte not fetched after key");
endmodule // orlm_top_props

bind orlm_top orlm_top_props u_props (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .FUSE_REQ(FUSE_REQ), .FUSE_PROG(FUSE_PROG),
	.FUSE_ADDR(FUSE_ADDR), .FUSE_RDATA(FUSE_RDATA), .LOCK(LOCK), .DBG_SWD_SEL(DBG_SWD_SEL),
	.DBG_ENABLE(DBG_ENABLE), .BOOT_DONE(BOOT_DONE));

`default_nettype wire

/* File: verification/orlm_fuse_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------
// Fuse array model
// ----------------
module orlm_fuse_model #(
	parameter logic [7:0] DBG_INIT = 8'h80
) (
	input wire logic MCLK,
	input wire logic FUSE_REQ,
	input wire logic FUSE_PROG,
	input wire logic [11:0] FUSE_ADDR,
	output logic [7:0] FUSE_RDATA
);
	logic [7:0] mem [0:511];
	// Blank array except the debug byte; survives resets like real fuses
	initial begin
		for (int i = 0; i < 512; i++) mem[i] = 8'h00;
		mem[9'h1E2] = DBG_INIT;
	end
	// Program sets one bit at the clock edge
	always @(posedge MCLK) begin
		if (FUSE_REQ && FUSE_PROG) mem[FUSE_ADDR[11:3]][FUSE_ADDR[2:0]] <= 1'b1;
	end
	// Read answers within the request cycle; otherwise the inverse shows, so a stray sample fails
	assign FUSE_RDATA = (FUSE_REQ && !FUSE_PROG) ? mem[FUSE_ADDR[11:3]] : ~mem[FUSE_ADDR[11:3]];
endmodule // orlm_fuse_model

`default_nettype wire

/* File: verification/test_otp_region_lock_map.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------
// Testbench
// ----------------
module test_otp_region_lock_map;
	import orlm_pkg::*;
	logic MCLK, RST_N, WR, RD, FUSE_REQ, FUSE_PROG, DBG_SWD_SEL, DBG_ENABLE, BOOT_DONE;
	logic [7:0] ADDR, FUSE_RDATA;
	logic [31:0] WDATA, RDATA, v;
	logic [3:0] LOCK;
	orlm_bitaddr_t FUSE_ADDR;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	orlm_top uut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .FUSE_REQ(FUSE_REQ), .FUSE_PROG(FUSE_PROG), .FUSE_ADDR(FUSE_ADDR),
		.FUSE_RDATA(FUSE_RDATA), .LOCK(LOCK), .DBG_SWD_SEL(DBG_SWD_SEL),
		.DBG_ENABLE(DBG_ENABLE), .BOOT_DONE(BOOT_DONE));
	orlm_fuse_model u_fuse (.MCLK(MCLK), .FUSE_REQ(FUSE_REQ), .FUSE_PROG(FUSE_PROG),
		.FUSE_ADDR(FUSE_ADDR), .FUSE_RDATA(FUSE_RDATA));
	// Clock
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask
	// Register write, one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
		#1;
	endtask
	// Register read; data taken in the cycle after the strobe
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		#1;
		v = RDATA;
		if (nm != "") chk(nm, v, exp);
	endtask
	// Fuse command: bit address then command, then let it finish
	task automatic fcmd(input logic [11:0] ba, input logic [31:0] c);
		wr(8'h0C, {20'h0, ba});
		wr(8'h10, c);
		repeat (4) @(posedge MCLK);
	endtask
	// Reset, optional early boot exit, wait for scan done
	task automatic boot(input logic early);
		@(posedge MCLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge MCLK);
		RST_N <= 1'b1;
		if (early) wr(8'h04, 32'h1);
		v = 32'h0;
		for (int i = 0; i < 200 && v[0] !== 1'b1; i++) rdc("", 8'h08, 32'h0);
		repeat (2) @(posedge MCLK);
		#1;
	endtask
	// Verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	// Main sequence
	initial begin
		RST_N = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 8'h00;
		WDATA = 32'h0;
		boot(1'b0);
		chk("lock", {28'h0, LOCK}, 32'h0);
		chk("swd", {31'h0, DBG_SWD_SEL}, 32'h0);
		chk("dbg_en", {31'h0, DBG_ENABLE}, 32'h1);
		chk("done0", {31'h0, BOOT_DONE}, 32'h0);
		rdc("debug", 8'h18, 32'h6);
		fcmd(12'h02A, 32'h2);
		fcmd(12'hF16, 32'h2);
		fcmd(12'h028, 32'h1);
		rdc("key_byte", 8'h14, 32'h4);
		wr(8'h04, 32'h1);
		chk("exit_lock", {28'h0, LOCK}, 32'h2);
		chk("exit_dbg", {31'h0, DBG_ENABLE}, 32'h0);
		chk("exit_done", {31'h0, BOOT_DONE}, 32'h1);
		wr(8'h00, 32'h0);
		rdc("lock_clr", 8'h00, 32'h2);
		wr(8'h00, 32'h1);
		rdc("lock_set", 8'h00, 32'h3);
		fcmd(12'h028, 32'h1);
		rdc("locked_rd", 8'h14, 32'h0);
		fcmd(12'h140, 32'h2);
		rdc("blocked", 8'h08, 32'h13);
		rdc("unmapped", 8'h1C, 32'h0);
		fcmd(12'hF10, 32'h1);
		rdc("cfg_rd", 8'h14, 32'hC0);
		wr(8'h00, 32'hC);
		rdc("lock_all", 8'h00, 32'hF);
		fcmd(12'hF10, 32'h1);
		rdc("cust_rd", 8'h14, 32'h0);
		$display("test open key done");
		boot(1'b1);
		chk("swd2", {31'h0, DBG_SWD_SEL}, 32'h1);
		chk("key_lock", {28'h0, LOCK}, 32'h3);
		rdc("status2", 8'h08, 32'h7);
		rdc("debug2", 8'h18, 32'h3);
		$display("test programmed key done");
		conclude();
	end
endmodule // test_otp_region_lock_map

`default_nettype wire
